// file: rtl/um_pkg.sv
// shared constants and carrier types of the 8x8 unsigned multiply datapath
// assumes the core runs one clock per instruction phase and provides reset
package um_pkg;

  // ==========================================================
  // widths
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 12;
  localparam int          BANK_W         = 4;
  localparam int          PROD_W         = 16;

  // ==========================================================
  // instruction word fields and opcodes
  localparam logic [7:0]  OPC_IMM        = 8'h0D;   // upper byte of immediate form
  localparam logic [6:0]  OPC_MEM        = 7'h01;   // upper seven bits of memory form
  localparam int          BANK_BIT_POS   = 8;       // bank-access bit in the word
  localparam int          OPC_IMM_LSB    = 8;
  localparam int          OPC_MEM_LSB    = 9;

  // ==========================================================
  // data memory addressing
  localparam logic [7:0]  IDX_LIMIT      = 8'h5F;   // highest indexed offset
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;   // access bank low/high split
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

  // ==========================================================
  // reset values
  localparam logic [15:0] PROD_RST       = 16'h0000;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [11:0] ADDR_RST       = 12'h000;
  localparam logic [7:0]  BYTE_RST       = 8'h00;

  // ==========================================================
  // phase sequencer states, one-hot
  typedef enum logic [4:0] {
    UM_IDLE    = 5'h01,
    UM_DECODE  = 5'h02,
    UM_READ    = 5'h04,
    UM_PROCESS = 5'h08,
    UM_WRITE   = 5'h10
  } um_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } um_instr_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } um_prod_t;

  typedef struct packed {
    logic acc_we;
    logic mem_we;
    logic status_we;
  } um_wb_t;

endpackage

// file: rtl/um_mult8.sv
// registered unsigned multiplier, result held until the next load
// assumes operands are stable during the load cycle
`timescale 1ns/1ps
module um_mult8 #(
  parameter int W = 8
) (
  input  wire logic           clock,
  input  wire logic           resetn,
  input  wire logic           load,
  input  wire logic [W-1:0]   opnd_a,
  input  wire logic [W-1:0]   opnd_b,
  output logic      [2*W-1:0] result
);

  logic [2*W-1:0] result_ff;
  logic [2*W-1:0] nxt_result;

  // ==========================================================
  // product, full double width so nothing is lost
  always_comb begin
    nxt_result = result_ff;
    if (load) begin
      nxt_result = (2*W)'(opnd_a) * (2*W)'(opnd_b);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      result_ff <= '0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  assign result = result_ff;

endmodule

// file: rtl/um_mul_unit.sv
// multiply datapath of the core: immediate and data-memory operand forms
// assumes the core presents one instruction word per handshake, the data
// memory answers a read in the same clock, and all inputs share this clock
//
// Notes on behaviour
// - immediate form multiplies accumulator by 8-bit literal into 16-bit pair
// - memory form multiplies accumulator by addressed byte into 16-bit pair
// - high product byte to high register, low byte to low register
// - accumulator and memory byte are never written by either form
// - no status flag is changed by either multiply
// - a zero product raises no indication at all
// - bank bit set uses bank select register, clear uses access bank
// - immediate form decoded from upper byte 0Dh, literal in lower byte
// - extended set, bank bit clear, offset up to 5Fh means indexed access
`timescale 1ns/1ps
module um_mul_unit
  import um_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire um_instr_t         instr,
  output logic                   instr_ready,
  input  wire logic [DATA_W-1:0] accumulator,
  input  wire logic [BANK_W-1:0] bank_select_reg,
  input  wire logic              ext_set_en,
  input  wire logic [ADDR_W-1:0] index_base,
  output logic                   mem_rd_en,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  output um_prod_t               product,
  output logic                   done,
  output um_wb_t                 wb
);

  um_state_t         state_ff, nxt_state;
  logic [15:0]       word_ff, nxt_word;
  logic              is_mem_ff, nxt_is_mem;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] acc_ff, nxt_acc;
  logic [DATA_W-1:0] opnd_ff, nxt_opnd;
  um_prod_t          prod_ff, nxt_prod;
  logic              done_ff, nxt_done;
  logic [PROD_W-1:0] mult_q;
  logic              dec_imm;
  logic              dec_mem;
  logic [7:0]        f_off;
  logic              bank_bit;

  // ==========================================================
  // decode of the held word
  assign f_off    = word_ff[7:0];
  assign bank_bit = word_ff[BANK_BIT_POS];
  assign dec_imm  = (word_ff[15:OPC_IMM_LSB] == OPC_IMM);
  assign dec_mem  = (word_ff[15:OPC_MEM_LSB] == OPC_MEM);

  // ==========================================================
  // phase sequencer and operand capture
  always_comb begin
    nxt_state  = state_ff;
    nxt_word   = word_ff;
    nxt_is_mem = is_mem_ff;
    nxt_addr   = addr_ff;
    nxt_acc    = acc_ff;
    nxt_opnd   = opnd_ff;
    nxt_done   = 1'b0;
    case (state_ff)
      UM_IDLE: begin
        if (instr.valid) begin
          nxt_word  = instr.word;
          nxt_state = UM_DECODE;
        end
      end
      UM_DECODE: begin
        // first phase: decide the form and where the operand lives
        nxt_is_mem = dec_mem;
        if (bank_bit) begin
          nxt_addr = {bank_select_reg, f_off};
        end else if (ext_set_en && (f_off <= IDX_LIMIT)) begin
          nxt_addr = index_base + ADDR_W'(f_off);
        end else if (f_off < ACCESS_SPLIT) begin
          nxt_addr = {ACCESS_LO_BANK, f_off};
        end else begin
          nxt_addr = {ACCESS_HI_BANK, f_off};
        end
        if (dec_imm || dec_mem) begin
          nxt_state = UM_READ;
        end else begin
          nxt_state = UM_IDLE;
        end
      end
      UM_READ: begin
        // second phase: take both operands, only read, never write back
        nxt_acc   = accumulator;
        nxt_opnd  = is_mem_ff ? mem_rd_data : f_off;
        nxt_state = UM_PROCESS;
      end
      UM_PROCESS: begin
        nxt_state = UM_WRITE;
      end
      UM_WRITE: begin
        nxt_done  = 1'b1;
        nxt_state = UM_IDLE;
      end
      default: begin
        nxt_state = UM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff  <= UM_IDLE;
      word_ff   <= WORD_RST;
      is_mem_ff <= 1'b0;
      addr_ff   <= ADDR_RST;
      acc_ff    <= BYTE_RST;
      opnd_ff   <= BYTE_RST;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      word_ff   <= nxt_word;
      is_mem_ff <= nxt_is_mem;
      addr_ff   <= nxt_addr;
      acc_ff    <= nxt_acc;
      opnd_ff   <= nxt_opnd;
      done_ff   <= nxt_done;
    end
  end

  // ==========================================================
  // third phase: multiply
  um_mult8 #(
    .W      (DATA_W)
  ) u_mult (
    .clock  (clock),
    .resetn (resetn),
    .load   (state_ff == UM_PROCESS),
    .opnd_a (acc_ff),
    .opnd_b (opnd_ff),
    .result (mult_q)
  );

  // ==========================================================
  // fourth phase: both product registers written together
  always_comb begin
    nxt_prod = prod_ff;
    if (state_ff == UM_WRITE) begin
      nxt_prod.high = mult_q[PROD_W-1:DATA_W];
      nxt_prod.low  = mult_q[DATA_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prod_ff <= PROD_RST;
    end else begin
      prod_ff <= nxt_prod;
    end
  end

  // ==========================================================
  // outputs; no zero indication and no writes to operands or flags
  assign instr_ready  = (state_ff == UM_IDLE);
  assign mem_rd_en    = (state_ff == UM_READ) && is_mem_ff;
  assign mem_addr     = addr_ff;
  assign product      = prod_ff;
  assign done         = done_ff;
  assign wb.acc_we    = 1'b0;
  assign wb.mem_we    = 1'b0;
  assign wb.status_we = 1'b0;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_imm_product: assert property (
    (done_ff && !is_mem_ff) |->
      ({prod_ff.high, prod_ff.low} == PROD_W'(acc_ff) * PROD_W'(opnd_ff))
  ) else $error("immediate product wrong");

  a_mem_product: assert property (
    (state_ff == UM_READ && is_mem_ff) |->
      ##3 ({prod_ff.high, prod_ff.low} ==
           PROD_W'($past(accumulator, 3)) * PROD_W'($past(mem_rd_data, 3)))
  ) else $error("memory product wrong");

  a_byte_order: assert property (
    done_ff |-> (prod_ff.high == mult_q[15:8]) && (prod_ff.low == mult_q[7:0])
  ) else $error("product bytes swapped");

  a_no_writeback: assert property (
    (state_ff != UM_IDLE) |-> !wb.acc_we && !wb.mem_we
  ) else $error("operand written back");

  a_flags_kept: assert property (
    (done_ff && (prod_ff == PROD_RST)) |-> !wb.status_we
  ) else $error("status changed by multiply");

  a_bank_select: assert property (
    (state_ff == UM_DECODE && bank_bit) |=>
      (mem_addr == {$past(bank_select_reg), word_ff[7:0]})
  ) else $error("bank select address wrong");

  a_access_bank: assert property (
    (state_ff == UM_DECODE && !bank_bit && !ext_set_en) |=>
      (mem_addr[11:8] == (word_ff[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK))
  ) else $error("access bank address wrong");

  a_imm_decode: assert property (
    (state_ff == UM_DECODE && word_ff[15:8] == OPC_IMM) |=>
      (state_ff == UM_READ) ##1 (opnd_ff == word_ff[7:0])
  ) else $error("immediate form not decoded");

  a_indexed_addr: assert property (
    (state_ff == UM_DECODE && !bank_bit && ext_set_en && word_ff[7:0] <= IDX_LIMIT) |=>
      (mem_addr == $past(index_base) + ADDR_W'(word_ff[7:0]))
  ) else $error("indexed address wrong");

  a_phase_order: assert property (
    (state_ff == UM_DECODE && (dec_imm || dec_mem)) |=>
      (state_ff == UM_READ) ##1 (state_ff == UM_PROCESS) ##1
      (state_ff == UM_WRITE) ##1 (done_ff && instr_ready)
  ) else $error("phase sequence broken");

endmodule

// file: sim/um_mul_unit_bench.sv
// self-checking bench for the multiply datapath, both operand forms
// assumes um_pkg is compiled first; the bench plays core and data memory
`timescale 1ns/1ps
module um_mul_unit_bench;
  import um_pkg::*;

  // ==========================================================
  // signals and instance
  logic                   clock;
  logic                   resetn;
  um_instr_t              instr;
  logic                   instr_ready;
  logic      [DATA_W-1:0] accumulator;
  logic      [BANK_W-1:0] bank_select_reg;
  logic                   ext_set_en;
  logic      [ADDR_W-1:0] index_base;
  logic                   mem_rd_en;
  logic      [ADDR_W-1:0] mem_addr;
  logic      [DATA_W-1:0] mem_rd_data;
  um_prod_t               product;
  logic                   done;
  um_wb_t                 wb;
  int                     mismatches;
  int                     checks_done;
  int                     cycles;

  um_mul_unit u_um_mul_unit (
    .clock           (clock),
    .resetn          (resetn),
    .instr           (instr),
    .instr_ready     (instr_ready),
    .accumulator     (accumulator),
    .bank_select_reg (bank_select_reg),
    .ext_set_en      (ext_set_en),
    .index_base      (index_base),
    .mem_rd_en       (mem_rd_en),
    .mem_addr        (mem_addr),
    .mem_rd_data     (mem_rd_data),
    .product         (product),
    .done            (done),
    .wb              (wb)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step;
    @(posedge clock);
    #2;
  endtask

  // one instruction: offer, then judge read phase and answer cycle
  task automatic issue(input logic [15:0] word, input logic [7:0] acc, input logic [7:0] mdata,
                       input logic is_mem, input logic [11:0] addr, input logic [15:0] prod,
                       input logic gives_done);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    instr.valid = 1'b1;
    instr.word  = word;
    accumulator = acc;
    mem_rd_data = mdata;
    step();
    instr.valid = 1'b0;
    step();
    check("mem_rd_en", {15'h0000, mem_rd_en}, {15'h0000, is_mem});
    check("instr_ready", {15'h0000, instr_ready}, {15'h0000, !gives_done});
    if (is_mem) check("mem_addr", {4'h0, mem_addr}, {4'h0, addr});
    step();
    step();
    check("done early", {15'h0000, done}, 16'h0000);
    step();
    check("done", {15'h0000, done}, {15'h0000, gives_done});
    check("product", product, prod);
    check("writeback", {13'h0000, wb}, 16'h0000);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_imm;
    issue(16'h0DC4, 8'hE2, 8'h00, 1'b0, 12'h000, 16'hAD08, 1'b1);
    issue(16'h0DFF, 8'hFF, 8'h00, 1'b0, 12'h000, 16'hFE01, 1'b1);
    issue(16'h0D05, 8'h03, 8'h00, 1'b0, 12'h000, 16'h000F, 1'b1);
    $display("test_imm done");
  endtask

  task automatic test_banked;
    bank_select_reg = 4'h5;
    issue(16'h0312, 8'hC4, 8'hB5, 1'b1, 12'h512, 16'h8A94, 1'b1);
    ext_set_en = 1'b1;
    issue(16'h0320, 8'h02, 8'h81, 1'b1, 12'h520, 16'h0102, 1'b1);
    ext_set_en = 1'b0;
    $display("test_banked done");
  endtask

  task automatic test_access;
    issue(16'h027F, 8'h10, 8'h10, 1'b1, 12'h07F, 16'h0100, 1'b1);
    issue(16'h0280, 8'h01, 8'h80, 1'b1, 12'hF80, 16'h0080, 1'b1);
    issue(16'h0220, 8'h03, 8'h03, 1'b1, 12'h020, 16'h0009, 1'b1);
    $display("test_access done");
  endtask

  task automatic test_indexed;
    ext_set_en = 1'b1;
    index_base = 12'h3F0;
    issue(16'h0220, 8'h02, 8'h02, 1'b1, 12'h410, 16'h0004, 1'b1);
    issue(16'h025F, 8'h04, 8'h04, 1'b1, 12'h44F, 16'h0010, 1'b1);
    issue(16'h0260, 8'h05, 8'h05, 1'b1, 12'h060, 16'h0019, 1'b1);
    index_base = 12'hFF0;
    issue(16'h0220, 8'h06, 8'h06, 1'b1, 12'h010, 16'h0024, 1'b1);
    ext_set_en = 1'b0;
    $display("test_indexed done");
  endtask

  task automatic test_zero;
    issue(16'h0D00, 8'h37, 8'h00, 1'b0, 12'h000, 16'h0000, 1'b1);
    issue(16'h0300, 8'h00, 8'hA5, 1'b1, 12'h500, 16'h0000, 1'b1);
    $display("test_zero done");
  endtask

  task automatic test_other;
    issue(16'h0D07, 8'h09, 8'h00, 1'b0, 12'h000, 16'h003F, 1'b1);
    issue(16'h0E12, 8'h05, 8'h00, 1'b0, 12'h000, 16'h003F, 1'b0);
    issue(16'h0412, 8'h05, 8'h22, 1'b0, 12'h000, 16'h003F, 1'b0);
    $display("test_other done");
  endtask

  // ==========================================================
  // verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mismatches      = 0;
    checks_done     = 0;
    cycles          = 0;
    resetn          = 1'b0;
    instr           = '0;
    accumulator     = 8'h00;
    bank_select_reg = 4'h0;
    ext_set_en      = 1'b0;
    index_base      = 12'h000;
    mem_rd_data     = 8'h00;
    repeat (10) step();
    resetn = 1'b1;
    check("reset product", product, 16'h0000);
    check("reset ready", {15'h0000, instr_ready}, 16'h0001);
    test_imm();
    test_banked();
    test_access();
    test_indexed();
    test_zero();
    test_other();
    complete_run();
  end
endmodule
